// ### rtl/l2_cache_timing_config.sv
// Purpose: l2 configuration register and the timing/polarity logic it steers
// Assumes: strobes one cycle wide, inputs synchronous to clock
// Notes:   other bits of the register belong to other blocks and read zero here
// Contract
// - snoop field sets snoop address phase waits 0..3, resets to 3
// - modified polarity bit sets active level of tag valid and dirty signals
// - match polarity applies only internally; external mode match is active low
// - address-only ignore bit makes clean, flush and kill go unanswered
// - tag hold bit holds tag outputs one clock after write, floats valid on read
// - read-for-modify miss fills a line unless fill disable bit set
// - match sampled 1..3 clocks after transfer start; 00 reserved; resets to 3
// - bank bit selects one or two data banks
// - quick evict bit always drives tag valid on reads
// - tag output enable lasts 2 clocks when clear, 3 when set
// - size field selects 256K, 512K, 1M; 11 reserved
// - cpu address waits field sets 0..3 waits, resets to 3
// - bit 15 is reserved, reads zero, controls nothing
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module l2_cache_timing_config (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  // register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic [31:0]                reg_rdata,
  // processor bus side
  input  wire l2_cfg_pkg::txn_s      txn,
  input  wire logic                  snoop_start,
  input  wire logic                  external_mode,
  output logic                       aphase_done,
  output logic                       snoop_done,
  output logic                       addronly_respond,
  output logic                       invalidate_req,
  output logic [31:0]                invalidate_addr,
  output logic                       line_fill_req,
  // tag ram side
  input  wire logic                  match_line,
  input  wire logic                  tag_valid_line_i,
  input  wire logic                  modified_line_input,
  input  wire logic                  tag_write_req,
  input  wire logic                  tag_read_req,
  input  wire logic                  tag_valid_wr,
  input  wire logic                  modified_wr,
  input  wire logic [31:0]           tag_addr_wr,
  input  wire logic                  castout_start,
  output logic                       tag_write_strobe_n,
  output logic [31:0]                tag_addr,
  output logic                       tag_addr_oe,
  output logic                       tag_valid_line_o,
  output logic                       tag_valid_line_oe,
  output logic                       modified_line_output,
  output logic                       modified_line_oe,
  output logic                       tag_output_enable,
  // decoded state
  output logic                       match_valid,
  output logic                       match_hit,
  output logic                       tag_valid_seen,
  output logic                       modified_seen,
  output logic                       dual_bank,
  output logic [1:0]                 capacity_index_extra,
  output logic                       capacity_reserved
);

  // ********************
  // helpers
  // ********************
  // clocks elapsed since a start; drops to zero after reaching 7 so a stale start never matches
  function automatic logic [2:0] elapse(input logic start, input logic [2:0] cur);
    if (start) begin
      elapse = 3'h1;
    end else if (cur != 3'h0 && cur != 3'h7) begin
      elapse = cur + 3'h1;
    end else begin
      elapse = 3'h0;
    end
  endfunction

  // ********************
  // configuration register
  // ********************
  l2_cfg_pkg::cfg_s cfg_q;
  logic             cfg_hit;
  logic [31:0]      cfg_word;

  assign cfg_hit = (reg_addr == l2_cfg_pkg::CFG_OFFSET);

  // packed view of the fields; reserved bit 15 stays zero
  always_comb begin
    cfg_word = 32'h0;
    cfg_word[l2_cfg_pkg::SNOOP_WS_LSB +: 2] = cfg_q.snoop_wait_states;
    cfg_word[l2_cfg_pkg::MOD_POL_BIT]       = cfg_q.modified_polarity_sel;
    cfg_word[l2_cfg_pkg::MATCH_POL_BIT]     = cfg_q.match_polarity_sel;
    cfg_word[l2_cfg_pkg::RSVD_BIT]          = 1'b0;
    cfg_word[l2_cfg_pkg::ADDRONLY_BIT]      = cfg_q.addronly_ignore;
    cfg_word[l2_cfg_pkg::HOLD_BIT]          = cfg_q.tag_write_hold;
    cfg_word[l2_cfg_pkg::INV_BIT]           = cfg_q.tag_invalidate_mode;
    cfg_word[l2_cfg_pkg::FILL_DIS_BIT]      = cfg_q.modify_read_fill_disable;
    cfg_word[l2_cfg_pkg::MATCH_DLY_LSB +: 2] = cfg_q.match_sample_delay;
    cfg_word[l2_cfg_pkg::BANK_BIT]          = cfg_q.dual_bank_sel;
    cfg_word[l2_cfg_pkg::QUICK_BIT]         = cfg_q.quick_evict_timing;
    cfg_word[l2_cfg_pkg::TOE_LEN_BIT]       = cfg_q.tag_oe_pulse_len;
    cfg_word[l2_cfg_pkg::SIZE_LSB +: 2]     = cfg_q.cache_capacity_sel;
    cfg_word[l2_cfg_pkg::CPU_WS_LSB +: 2]   = cfg_q.cpu_addr_wait_states;
  end

  // field store; reserved codes are kept as written so readback is exact
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= '0;
      cfg_q.snoop_wait_states    <= l2_cfg_pkg::WS_RESET;
      cfg_q.match_sample_delay   <= l2_cfg_pkg::DLY_RESET;
      cfg_q.cpu_addr_wait_states <= l2_cfg_pkg::WS_RESET;
    end else if (reg_write && cfg_hit) begin
      cfg_q.snoop_wait_states        <= reg_wdata[l2_cfg_pkg::SNOOP_WS_LSB +: 2];
      cfg_q.modified_polarity_sel    <= reg_wdata[l2_cfg_pkg::MOD_POL_BIT];
      cfg_q.match_polarity_sel       <= reg_wdata[l2_cfg_pkg::MATCH_POL_BIT];
      cfg_q.addronly_ignore          <= reg_wdata[l2_cfg_pkg::ADDRONLY_BIT];
      cfg_q.tag_write_hold           <= reg_wdata[l2_cfg_pkg::HOLD_BIT];
      cfg_q.tag_invalidate_mode      <= reg_wdata[l2_cfg_pkg::INV_BIT];
      cfg_q.modify_read_fill_disable <= reg_wdata[l2_cfg_pkg::FILL_DIS_BIT];
      cfg_q.match_sample_delay       <= reg_wdata[l2_cfg_pkg::MATCH_DLY_LSB +: 2];
      cfg_q.dual_bank_sel            <= reg_wdata[l2_cfg_pkg::BANK_BIT];
      cfg_q.quick_evict_timing       <= reg_wdata[l2_cfg_pkg::QUICK_BIT];
      cfg_q.tag_oe_pulse_len         <= reg_wdata[l2_cfg_pkg::TOE_LEN_BIT];
      cfg_q.cache_capacity_sel       <= reg_wdata[l2_cfg_pkg::SIZE_LSB +: 2];
      cfg_q.cpu_addr_wait_states     <= reg_wdata[l2_cfg_pkg::CPU_WS_LSB +: 2];
    end
  end

  // read data one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_read && cfg_hit) begin
      reg_rdata <= cfg_word;
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  a_readback_exact: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_write && cfg_hit) ##1 !reg_write ##1 (reg_read && cfg_hit && !reg_write) |=>
      reg_rdata == ($past(reg_wdata, 3) & 32'h000f7ffc))
    else $error("register readback differs from written value");
  a_rsvd_zero: assert property (@(posedge clock) disable iff (!arst_n)
    !reg_rdata[l2_cfg_pkg::RSVD_BIT])
    else $error("reserved bit 15 read as one");

  // ********************
  // address phase timing
  // ********************
  logic [2:0] cpu_elapsed_q;
  logic [2:0] snoop_elapsed_q;

  // one counter per tenure kind; a new start restarts it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cpu_elapsed_q   <= 3'h0;
      snoop_elapsed_q <= 3'h0;
    end else begin
      cpu_elapsed_q   <= elapse(txn.transfer_start, cpu_elapsed_q);
      snoop_elapsed_q <= elapse(snoop_start, snoop_elapsed_q);
    end
  end

  // phase of 2+ws clocks ends in the cycle ws+1 after the start
  assign aphase_done = (cpu_elapsed_q ==
    l2_cfg_pkg::APHASE_BASE + {1'b0, cfg_q.cpu_addr_wait_states});
  assign snoop_done  = (snoop_elapsed_q ==
    l2_cfg_pkg::APHASE_BASE + {1'b0, cfg_q.snoop_wait_states});

  a_cpu_ws_three: assert property (@(posedge clock) disable iff (!arst_n)
    (txn.transfer_start && cfg_q.cpu_addr_wait_states == 2'h3 && !reg_write)
      ##1 (!txn.transfer_start && !reg_write)[*3] |=> aphase_done)
    else $error("cpu address phase did not end after three waits");
  a_snoop_min: assert property (@(posedge clock) disable iff (!arst_n)
    (snoop_start && !reg_write) |=> snoop_done == (cfg_q.snoop_wait_states == 2'h0))
    else $error("snoop address phase of wrong length");

  // ********************
  // match sampling and polarity
  // ********************
  logic [1:0] eff_delay;
  logic       match_active;
  logic       rfm_q;

  // reserved code 00 falls back to the slowest, safest sample point
  assign eff_delay = (cfg_q.match_sample_delay == 2'h0) ? l2_cfg_pkg::DLY_RESET
                                                        : cfg_q.match_sample_delay;
  assign match_valid = (cpu_elapsed_q == {1'b0, eff_delay});
  // external controller always sees match active low
  assign match_active = external_mode ? !match_line
                                      : (match_line == cfg_q.match_polarity_sel);

  // match state caught at the sample point; read kind kept from the start
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      match_hit <= 1'b0;
      rfm_q     <= 1'b0;
    end else begin
      if (txn.transfer_start) begin
        rfm_q <= txn.read_for_modify;
      end
      if (match_valid) begin
        match_hit <= match_active;
      end
    end
  end

  // miss fill; a modify read skips it when the disable bit is set
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      line_fill_req <= 1'b0;
    end else begin
      line_fill_req <= match_valid && !match_active && !external_mode
                       && (!rfm_q || !cfg_q.modify_read_fill_disable);
    end
  end

  a_match_delay_one: assert property (@(posedge clock) disable iff (!arst_n)
    (txn.transfer_start && cfg_q.match_sample_delay == 2'h1 && !reg_write) |=> match_valid)
    else $error("match not sampled one clock after start");
  a_fill_skip: assert property (@(posedge clock) disable iff (!arst_n)
    (match_valid && rfm_q && cfg_q.modify_read_fill_disable) |=> !line_fill_req)
    else $error("line fill issued for modify read with fill disabled");

  // ********************
  // bus transaction responses
  // ********************
  // registered one-cycle pulses per transaction start
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      addronly_respond <= 1'b0;
      invalidate_req   <= 1'b0;
      invalidate_addr  <= 32'h0;
    end else begin
      addronly_respond <= txn.transfer_start && txn.addr_only
                          && !cfg_q.addronly_ignore && !external_mode;
      invalidate_req   <= txn.transfer_start && cfg_q.tag_invalidate_mode
                          && !external_mode;
      if (txn.transfer_start) begin
        invalidate_addr <= txn.addr;
      end
    end
  end

  a_addronly_ign: assert property (@(posedge clock) disable iff (!arst_n)
    (txn.transfer_start && cfg_q.addronly_ignore) |=> !addronly_respond)
    else $error("address-only transaction answered while ignored");
  a_inval_every: assert property (@(posedge clock) disable iff (!arst_n)
    (txn.transfer_start && cfg_q.tag_invalidate_mode && !external_mode)
      |=> invalidate_req && invalidate_addr == $past(txn.addr))
    else $error("transaction in invalidate mode gave no invalidate");

  // ********************
  // tag write, hold and valid drive
  // ********************
  logic hold_q;
  logic write_prev_q;
  logic drive_on_read;

  // tag outputs captured at the active polarity while writing
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tag_addr             <= 32'h0;
      tag_valid_line_o     <= 1'b0;
      modified_line_output <= 1'b0;
    end else if (tag_write_req) begin
      tag_addr             <= tag_addr_wr;
      tag_valid_line_o     <= tag_valid_wr == cfg_q.modified_polarity_sel;
      modified_line_output <= modified_wr == cfg_q.modified_polarity_sel;
    end
  end

  // hold window: one clock after the strobe negates, asynchronous tag rams only
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      write_prev_q <= 1'b0;
      hold_q       <= 1'b0;
    end else begin
      write_prev_q <= tag_write_req;
      hold_q       <= write_prev_q && cfg_q.tag_write_hold;
    end
  end

  // float on reads only when both hold and normal castout ask for it
  assign drive_on_read      = !cfg_q.tag_write_hold || cfg_q.quick_evict_timing;
  assign tag_write_strobe_n = !write_prev_q;
  assign tag_addr_oe        = write_prev_q || (hold_q && !write_prev_q);
  assign modified_line_oe   = tag_addr_oe;
  assign tag_valid_line_oe  = tag_addr_oe || (tag_read_req && drive_on_read);
  // inputs decoded to logical true-means-set
  assign tag_valid_seen     = tag_valid_line_i == cfg_q.modified_polarity_sel;
  assign modified_seen      = modified_line_input == cfg_q.modified_polarity_sel;

  a_hold_one: assert property (@(posedge clock) disable iff (!arst_n)
    (write_prev_q && !tag_write_req && cfg_q.tag_write_hold) |=>
      tag_write_strobe_n && tag_addr_oe ##1 !tag_addr_oe || tag_write_req)
    else $error("tag hold not exactly one clock");
  a_valid_float: assert property (@(posedge clock) disable iff (!arst_n)
    (tag_read_req && !tag_addr_oe && cfg_q.quick_evict_timing) |-> tag_valid_line_oe)
    else $error("tag valid floated with quick evict timing");

  // ********************
  // tag output enable pulse
  // ********************
  logic [1:0] toe_cnt_q;

  // pulse length follows the width bit at the start of each castout
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      toe_cnt_q <= 2'h0;
    end else if (castout_start) begin
      toe_cnt_q <= cfg_q.tag_oe_pulse_len ? l2_cfg_pkg::TOE_LONG
                                          : l2_cfg_pkg::TOE_SHORT;
    end else if (toe_cnt_q != 2'h0) begin
      toe_cnt_q <= toe_cnt_q - 2'h1;
    end
  end

  assign tag_output_enable = (toe_cnt_q != 2'h0);

  a_toe_short: assert property (@(posedge clock) disable iff (!arst_n)
    (castout_start && !cfg_q.tag_oe_pulse_len) ##1 !castout_start[*2] |->
      $past(tag_output_enable) && tag_output_enable ##1 !tag_output_enable)
    else $error("tag output enable not two clocks");

  // ********************
  // geometry
  // ********************
  // extra index bits beyond the smallest size; reserved code treated as smallest
  assign dual_bank            = cfg_q.dual_bank_sel;
  assign capacity_reserved    = (cfg_q.cache_capacity_sel == 2'h3);
  assign capacity_index_extra = capacity_reserved ? 2'h0 : cfg_q.cache_capacity_sel;

  a_size_map: assert property (@(posedge clock) disable iff (!arst_n)
    capacity_reserved |-> capacity_index_extra == 2'h0)
    else $error("reserved size code decoded to a size");

endmodule // l2_cache_timing_config

// ### rtl/l2_cfg_pkg.sv
// Purpose: shared constants and carriers for the l2 timing configuration block
// Assumes: 32-bit register port, one clock
// Notes:   field positions refer to l2_processor_interface_config
package l2_cfg_pkg;
  // ********************
  // register map
  // ********************
  localparam logic [7:0]  CFG_OFFSET   = 8'hac;
  localparam logic [31:0] CFG_RESET    = 32'h000c060c;
  localparam int          SNOOP_WS_LSB = 18;
  localparam int          MOD_POL_BIT  = 17;
  localparam int          MATCH_POL_BIT = 16;
  localparam int          RSVD_BIT     = 15;
  localparam int          ADDRONLY_BIT = 14;
  localparam int          HOLD_BIT     = 13;
  localparam int          INV_BIT      = 12;
  localparam int          FILL_DIS_BIT = 11;
  localparam int          MATCH_DLY_LSB = 9;
  localparam int          BANK_BIT     = 8;
  localparam int          QUICK_BIT    = 7;
  localparam int          TOE_LEN_BIT  = 6;
  localparam int          SIZE_LSB     = 4;
  localparam int          CPU_WS_LSB   = 2;
  localparam logic [1:0]  WS_RESET     = 2'h3;
  localparam logic [1:0]  DLY_RESET    = 2'h3;
  // ********************
  // timing counts
  // ********************
  localparam logic [2:0]  APHASE_BASE  = 3'h1; // zero waits: done one clock after start
  localparam logic [1:0]  TOE_SHORT    = 2'h2;
  localparam logic [1:0]  TOE_LONG     = 2'h3;
  // ********************
  // carriers
  // ********************
  typedef struct packed {
    logic [1:0] snoop_wait_states;
    logic       modified_polarity_sel;
    logic       match_polarity_sel;
    logic       addronly_ignore;
    logic       tag_write_hold;
    logic       tag_invalidate_mode;
    logic       modify_read_fill_disable;
    logic [1:0] match_sample_delay;
    logic       dual_bank_sel;
    logic       quick_evict_timing;
    logic       tag_oe_pulse_len;
    logic [1:0] cache_capacity_sel;
    logic [1:0] cpu_addr_wait_states;
  } cfg_s;
  typedef struct packed {
    logic        transfer_start;
    logic        addr_only;
    logic        read_for_modify;
    logic [31:0] addr;
  } txn_s;
endpackage

// ### test/l2_cache_timing_config_tb_top.sv
// Purpose: self-checking bench for the l2 timing configuration block
// Assumes: tag ram model on the pin side, bench drives everything else
// Notes:   expected results queue per output kind, monitor pops on each pulse
`timescale 1ns/1ps
module l2_cache_timing_config_tb_top;
  logic clock = 1'b0, arst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, invalidate_addr, tag_addr, tag_addr_wr = 32'h0;
  l2_cfg_pkg::txn_s txn = '0;
  logic snoop_start = 1'b0, external_mode = 1'b0, castout_start = 1'b0;
  logic tag_write_req = 1'b0, tag_read_req = 1'b0, tag_valid_wr = 1'b0, modified_wr = 1'b0;
  logic aphase_done, snoop_done, addronly_respond, invalidate_req, line_fill_req, match_line;
  logic tv_pin, mod_pin, tv_wire, mod_wire, tag_write_strobe_n, tag_addr_oe, tag_valid_line_o;
  logic tag_valid_line_oe, modified_line_output, modified_line_oe, tag_output_enable;
  logic match_valid, match_hit, tag_valid_seen, modified_seen, dual_bank, capacity_reserved;
  logic [1:0] capacity_index_extra;
  logic [31:0] exp_q [10][$];
  logic [31:0] c = l2_cfg_pkg::CFG_RESET;
  logic [15:0] s = 16'he6a0;
  string nm [10] = '{"rdata", "aphase", "snoop", "match_dly", "toe_len", "inv_addr",
                     "addronly", "fill", "match_hit", "tag_oe_len"};
  int n_mismatch = 0, total_checks = 0, cyc = 0, t_st = 0, t_sn = 0, toe_n = 0, aoe_n = 0;
  logic rd_pend = 1'b0, mv_pend = 1'b0, ext = 1'b0;
  always #2.5 clock = ~clock;
  // two-way pins resolve between block and tag ram
  assign tv_wire  = tag_valid_line_oe ? tag_valid_line_o : tv_pin;
  assign mod_wire = modified_line_oe ? modified_line_output : mod_pin;
  l2_cache_timing_config u_l2_cache_timing_config (.clock(clock), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .txn(txn), .snoop_start(snoop_start), .external_mode(external_mode),
    .aphase_done(aphase_done), .snoop_done(snoop_done), .addronly_respond(addronly_respond),
    .invalidate_req(invalidate_req), .invalidate_addr(invalidate_addr),
    .line_fill_req(line_fill_req), .match_line(match_line), .tag_valid_line_i(tv_wire),
    .modified_line_input(mod_wire), .tag_write_req(tag_write_req), .tag_read_req(tag_read_req),
    .tag_valid_wr(tag_valid_wr), .modified_wr(modified_wr), .tag_addr_wr(tag_addr_wr),
    .castout_start(castout_start), .tag_write_strobe_n(tag_write_strobe_n),
    .tag_addr(tag_addr), .tag_addr_oe(tag_addr_oe), .tag_valid_line_o(tag_valid_line_o),
    .tag_valid_line_oe(tag_valid_line_oe), .modified_line_output(modified_line_output),
    .modified_line_oe(modified_line_oe), .tag_output_enable(tag_output_enable),
    .match_valid(match_valid), .match_hit(match_hit), .tag_valid_seen(tag_valid_seen),
    .modified_seen(modified_seen), .dual_bank(dual_bank),
    .capacity_index_extra(capacity_index_extra), .capacity_reserved(capacity_reserved));
  tag_ram_model u_tag_ram_model (.clock(clock), .arst_n(arst_n), .txn(txn), .mod_pol(c[17]),
    .match_pol(c[16]), .ext(ext), .match_line(match_line), .tv_pin(tv_pin), .mod_pin(mod_pin));
  // **********************
  // checking helpers
  // **********************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic push(input int k, input logic [31:0] v);
    exp_q[k].push_back(v);
  endtask
  // a pulse with nothing expected is itself a mismatch
  task automatic take(input int k, input logic [31:0] g);
    if (exp_q[k].size() == 0) chk(nm[k], 32'hdead_0000, g);
    else chk(nm[k], exp_q[k].pop_front(), g);
  endtask
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // **********************
  // register bus and stimulus
  // **********************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    push(0, e);
    @(posedge clock);
    reg_addr <= a; reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
  endtask
  task automatic start(input logic rfm, input logic ao);
    logic [31:0] a;
    logic [1:0]  d;
    s = nxt(s);
    a = {s, ~s};
    if (ao) a[5] = 1'b1;
    d = (c[10:9] == 2'h0) ? 2'h3 : c[10:9];
    push(1, 32'(c[3:2]) + 1); push(3, 32'(d)); push(8, 32'(a[5]));
    if (!ext) begin
      if (c[12]) push(5, a);
      if (ao && !c[14]) push(6, 1);
      if (!a[5] && !(rfm && c[11])) push(7, 32'(d) + 1);
    end
    @(posedge clock);
    txn <= '{transfer_start: 1'b1, addr_only: ao, read_for_modify: rfm, addr: a};
    @(posedge clock);
    txn.transfer_start <= 1'b0;
    @(posedge clock);
    chk("tag_valid_seen", 32'(a[6]), 32'(tag_valid_seen));
    chk("modified_seen", 32'(a[7]), 32'(modified_seen));
    repeat (6) @(posedge clock);
  endtask
  // **********************
  // output monitor
  // **********************
  // samples at the edge, so it sees the values of the cycle just ended
  always @(posedge clock) begin
    cyc++;
    if (rd_pend) take(0, reg_rdata);
    rd_pend = reg_read;
    if (mv_pend) take(8, 32'(match_hit));
    mv_pend = match_valid;
    if (txn.transfer_start) t_st = cyc;
    if (snoop_start) t_sn = cyc;
    if (aphase_done) take(1, 32'(cyc - t_st));
    if (snoop_done) take(2, 32'(cyc - t_sn));
    if (match_valid) take(3, 32'(cyc - t_st));
    if (invalidate_req) take(5, invalidate_addr);
    if (addronly_respond) take(6, 32'(cyc - t_st));
    if (line_fill_req) take(7, 32'(cyc - t_st));
    if (tag_output_enable) toe_n++;
    else if (toe_n != 0) begin
      take(4, 32'(toe_n));
      toe_n = 0;
    end
    if (tag_addr_oe) aoe_n++;
    else if (aoe_n != 0) begin
      take(9, 32'(aoe_n));
      aoe_n = 0;
    end
  end
  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
  // **********************
  // main sequence
  // **********************
  initial begin
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    rd(8'hac, 32'h000c_060c);
    wr(8'hac, 32'hffff_ffff);
    rd(8'hac, 32'h000f_7ffc);
    wr(8'h10, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'hac, 32'h000f_7ffc);
    for (int j = 0; j < 2; j++) begin
      ext = j[0];
      external_mode <= j[0];
      for (int i = 0; i < 4; i++) begin
        c = (32'(i) << 18) | (32'(i[0]) << 17) | (32'(i[1]) << 16) | (32'(i[1]) << 14)
          | (32'(i[1]) << 13) | (32'(i[0]) << 12) | (32'(i[1]) << 11) | (32'(i) << 9)
          | (32'(i[0]) << 8) | (32'(i[0]) << 7) | (32'(i[0]) << 6) | (32'(i) << 4)
          | (32'(i) << 2);
        wr(8'hac, c);
        rd(8'hac, c);
        chk("dual_bank", 32'(i[0]), 32'(dual_bank));
        chk("capacity", (i == 3) ? 32'h0 : 32'(i), 32'(capacity_index_extra));
        chk("cap_rsvd", 32'(i == 3), 32'(capacity_reserved));
        start(1'b0, 1'b0);
        start(1'b1, 1'b0);
        start(1'b1, 1'b0);
        start(1'b0, 1'b1);
        push(2, 32'(c[19:18]) + 1);
        snoop_start <= 1'b1;
        @(posedge clock);
        snoop_start <= 1'b0;
        push(4, c[6] ? 32'h3 : 32'h2);
        castout_start <= 1'b1;
        @(posedge clock);
        castout_start <= 1'b0;
        repeat (6) @(posedge clock);
        s = nxt(s);
        push(9, c[13] ? 32'h2 : 32'h1);
        tag_write_req <= 1'b1; tag_addr_wr <= {~s, s}; tag_valid_wr <= s[0]; modified_wr <= s[1];
        @(posedge clock);
        tag_write_req <= 1'b0;
        @(posedge clock);
        chk("strobe_lo", 32'h0, 32'(tag_write_strobe_n));
        chk("dirty_oe", 32'h1, 32'(modified_line_oe));
        @(posedge clock);
        chk("dirty_oe_hold", 32'(c[13]), 32'(modified_line_oe));
        @(posedge clock);
        chk("strobe_hi", 32'h1, 32'(tag_write_strobe_n));
        chk("dirty_oe_off", 32'h0, 32'(modified_line_oe));
        chk("tag_addr", {~s, s}, tag_addr);
        chk("tv_out", 32'(s[0] ^ !c[17]), 32'(tag_valid_line_o));
        chk("modified_line_output", 32'(s[1] ^ !c[17]), 32'(modified_line_output));
        tag_read_req <= 1'b1;
        repeat (2) @(posedge clock);
        chk("tv_oe_read", 32'(!(c[13] && !c[7])), 32'(tag_valid_line_oe));
        tag_read_req <= 1'b0;
        repeat (3) @(posedge clock);
      end
    end
    for (int k = 0; k < 10; k++) chk(nm[k], 32'h0, 32'(exp_q[k].size()));
    give_verdict();
  end
endmodule // l2_cache_timing_config_tb_top

// ### test/tag_ram_model.sv
// Purpose: behavioural tag ram answering lookups of the l2 timing block
// Assumes: hit, valid and dirty of a lookup come from address bits 5, 6 and 7
// Notes:   outside a lookup window the pins toggle so stale values never pass
`timescale 1ns/1ps
module tag_ram_model (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              arst_n,
  // lookup request and pin polarity
  input  wire l2_cfg_pkg::txn_s  txn,
  input  wire logic              mod_pol,
  input  wire logic              match_pol,
  input  wire logic              ext,
  // tag pins
  output logic                   match_line,
  output logic                   tv_pin,
  output logic                   mod_pin
);
  logic [31:0] a_q;
  logic [2:0]  win_q;
  logic        tog_q;
  logic        hit_high;
  // **********************
  // lookup window
  // **********************
  // window covers the longest match delay with two cycles to spare
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      a_q   <= 32'h0;
      win_q <= 3'h0;
      tog_q <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
      if (txn.transfer_start) begin
        a_q   <= txn.addr;
        win_q <= 3'h5;
      end else if (win_q != 3'h0) begin
        win_q <= win_q - 3'h1;
      end
    end
  end
  // pin levels, external controller always sees match active low
  assign hit_high   = match_pol && !ext;
  assign match_line = (win_q != 3'h0) ? (a_q[5] ^ !hit_high) : tog_q;
  assign tv_pin     = (win_q != 3'h0) ? (a_q[6] ^ !mod_pol) : ~tog_q;
  assign mod_pin    = (win_q != 3'h0) ? (a_q[7] ^ !mod_pol) : tog_q;
endmodule // tag_ram_model
